//--- owm_pkg.sv
// Purpose: constants, field layout and carrier types for the window mode setup block
// Assumes: byte offsets relative to the block base, 32-bit Avalon-MM data
// Notes:   all reset values are zero; reserved bits are masked on write and read as zero
//
// Function
// R1 - video window zoom codes 0,1h,2h give x1,x2,x4; code 3h acts as 0
// R2 - sign flip bit counts only when a field split bit is set; 0 inverts
// R3 - video window 1 split bit counts only with stretch and smoothing on
// R4 - video window 0 split bit counts only with stretch and smoothing on
// R5 - field read mode fetches each stored line once per field or frame
// R6 - frame read mode fetches alternate lines per field; interlaced encoder only
// R7 - software programs height as half for interlaced, full for progressive field mode
// R8 - a video window is shown only while its show bit is one
// R9 - mode, zoom, show, table, depth, blend and key settings latch at frame sync; code reads the key colour in key_reg unlatched
// R10 - overlay range squeeze gives luma 16-235, chroma 16-240 unless overlay 1 is attribute; code tops out at luma 234, chroma 239
// R11 - overlay RGB input reads 16-bit pixels, luma 0.299R+0.587G+0.114B
// R12 - chroma Cb and Cr from fixed coefficients plus offset 128
// R13 - software never enables RGB input on both overlays together
// R14 - overlay 0 table select 0 picks ROM table, 1 picks RAM table
// R15 - overlay zoom codes 0,1h,2h give x1,x2,x4; code 3h acts as 0
// R16 - depth codes give 1,2,4,8 bits per pixel; RGB input forces 16
// R17 - blend code n weights overlay n/8, video (8-n)/8; 7h is full overlay
// R18 - key off blends whole window; key on in bitmap blends only index-zero pixels
// R19 - key on in RGB mode blends only pixels equal to the key colour
// R20 - overlay 0 shown only while its show bit is one
// R21 - overlay 1 attribute select 0 is bitmap, 1 is attribute; latched at sync
// R22 - overlay 1 squeeze and RGB apply only while attribute select is zero
// R23 - smoothing filter needs stretch and covers at most 720 pixels per line
// R24 - vertical stretch enlarges video by 6/5
// R25 - shadow copies load from software registers on the frame sync pulse
package owm_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0]  OFS_MODE  = 8'h00;
    localparam logic [7:0]  OFS_VID   = 8'h04;
    localparam logic [7:0]  OFS_OVL0  = 8'h08;
    localparam logic [7:0]  OFS_OVL1  = 8'h0c;
    localparam logic [7:0]  OFS_KEY   = 8'hf4;
    localparam logic [7:0]  OFS_STAT  = 8'hf8;
    localparam logic [31:0] RST_MODE  = 32'h0000_0000;
    localparam logic [31:0] RST_VID   = 32'h0000_0000;
    localparam logic [31:0] RST_OVL   = 32'h0000_0000;
    localparam logic [31:0] RST_KEY   = 32'h0000_0000;
    localparam logic [31:0] MASK_MODE = 32'h0000_1800;
    localparam logic [31:0] MASK_VID  = 32'h0000_ff7f;
    localparam logic [31:0] MASK_OVL0 = 32'h0000_7fff;
    localparam logic [31:0] MASK_OVL1 = 32'h0000_ffff;
    localparam logic [31:0] MASK_KEY  = 32'h0000_ffff;
    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int MODE_SMOOTH = 12;
    localparam int MODE_VSTR   = 11;
    localparam int VID_FLIP    = 15;
    localparam int V1_SPLIT    = 14;
    localparam int V1_HZ       = 12;
    localparam int V1_VZ       = 10;
    localparam int V1_FRM      = 9;
    localparam int V1_SHOW     = 8;
    localparam int V0_SPLIT    = 6;
    localparam int V0_HZ       = 4;
    localparam int V0_VZ       = 2;
    localparam int V0_FRM      = 1;
    localparam int V0_SHOW     = 0;
    localparam int O_ATTR      = 15;
    localparam int O_SQZ       = 14;
    localparam int O_RGB       = 13;
    localparam int O_TBL       = 12;
    localparam int O_HZ        = 10;
    localparam int O_VZ        = 8;
    localparam int O_BPP       = 6;
    localparam int O_MIX       = 3;
    localparam int O_KEY       = 2;
    localparam int O_FRM       = 1;
    localparam int O_SHOW      = 0;
    // ---------------------------------------------------------------
    // arithmetic constants (coefficients scaled by 256)
    // ---------------------------------------------------------------
    localparam logic signed [19:0] K_Y_R    = 20'sd77;
    localparam logic signed [19:0] K_Y_G    = 20'sd150;
    localparam logic signed [19:0] K_Y_B    = 20'sd29;
    localparam logic signed [19:0] K_CB_R   = 20'sd43;
    localparam logic signed [19:0] K_CB_G   = 20'sd85;
    localparam logic signed [19:0] K_CB_B   = 20'sd128;
    localparam logic signed [19:0] K_CR_R   = 20'sd128;
    localparam logic signed [19:0] K_CR_G   = 20'sd107;
    localparam logic signed [19:0] K_CR_B   = 20'sd21;
    localparam logic signed [19:0] K_OFS    = 20'sd32768;
    localparam logic [15:0]        SQZ_GY   = 16'd219;
    localparam logic [15:0]        SQZ_GC   = 16'd224;
    localparam logic [7:0]         SQZ_BASE = 8'd16;
    localparam logic [3:0]         MIX_FULL = 4'd8;
    localparam logic [10:0]        LINE_MAX = 11'd720;
    localparam logic [2:0]         STR_LAST = 3'd4;
    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } owm_ycc_t;
    typedef struct packed {
        logic       show;
        logic       frame_mode;
        logic [2:0] hmag;
        logic [2:0] vmag;
    } owm_vid_cfg_t;
    typedef struct packed {
        logic       show;
        logic       frame_mode;
        logic       key_en;
        logic       table_ram;
        logic       rgb;
        logic       squeeze;
        logic [2:0] mix;
        logic [4:0] bpp;
        logic [2:0] hmag;
        logic [2:0] vmag;
    } owm_ovl_cfg_t;
    typedef struct packed {
        logic step2;
        logic start_odd;
    } owm_fetch_t;
endpackage

//--- owm_window_mode.sv
// Purpose: window mode registers, frame-sync shadows and overlay pixel mixer
// Assumes: single 250 MHz display clock, synchronous active-low reset
// Notes:   one wait state per bus access; settings except the key colour move to shadows on frame sync
`timescale 1ns/1ps
module owm_window_mode
    import owm_pkg::*;
(
    input  wire logic         clk,              // display clock
    input  wire logic         rst_n,            // sync reset, active low
    input  wire logic [7:0]   address,          // avalon byte address
    input  wire logic         read,             // avalon read
    input  wire logic         write,            // avalon write
    input  wire logic [31:0]  writedata,        // avalon write data
    input  wire logic [3:0]   byteenable,       // avalon byte lanes
    output logic [31:0]       readdata,         // avalon read data
    output logic              waitrequest,      // avalon wait
    input  wire logic         frame_sync_pulse, // one-cycle frame sync
    input  wire logic         field_odd,        // field at next sync
    input  wire logic         line_pulse,       // one pulse per output line
    input  wire logic [10:0]  vid_line_width,   // video pixels per line
    output owm_vid_cfg_t      vid0_cfg,         // video window 0 settings
    output owm_vid_cfg_t      vid1_cfg,         // video window 1 settings
    output owm_ovl_cfg_t      ovl0_cfg,         // overlay 0 settings
    output owm_ovl_cfg_t      ovl1_cfg,         // overlay 1 settings
    output logic              ovl1_attr_mode,   // overlay 1 is attribute window
    output owm_fetch_t        vid0_fetch,       // line fetch pattern
    output owm_fetch_t        vid1_fetch,       // line fetch pattern
    output owm_fetch_t        ovl0_fetch,       // line fetch pattern
    output owm_fetch_t        ovl1_fetch,       // line fetch pattern
    output logic              vid_stretch_on,   // 6/5 vertical stretch
    output logic              stretch_repeat,   // repeat this source line
    output logic              filter_active,    // smoothing filter running
    output logic              vid0_coef_split,  // per-field taps, window 0
    output logic              vid1_coef_split,  // per-field taps, window 1
    output logic              coef_invert,      // use inverted taps
    input  wire logic         pix_valid,        // overlay pixel strobe
    input  wire logic         pix_ovl_sel,      // 0 overlay 0, 1 overlay 1
    input  wire logic [15:0]  pix_raw,          // bitmap index or rgb565
    input  owm_ycc_t          pix_pal,          // palette colour for index
    input  owm_ycc_t          pix_vid,          // video window 0 pixel
    output logic              out_valid,        // mixed pixel strobe
    output owm_ycc_t          out_pix           // mixed pixel
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [2:0] zoom_mag(input logic [1:0] code);
        unique case (code)
            2'h1:    zoom_mag = 3'd2;
            2'h2:    zoom_mag = 3'd4;
            default: zoom_mag = 3'd1;  // code 3 behaves like 0
        endcase
    endfunction

    function automatic logic [4:0] bpp_dec(input logic [1:0] code, input logic rgb);
        if (rgb) begin
            bpp_dec = 5'd16;
        end else begin
            bpp_dec = 5'd1 << code;
        end
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge_be = ((old & ~bm) | (wd & bm)) & mask;
    endfunction

    function automatic owm_ovl_cfg_t ovl_dec(input logic [31:0] r, input logic gate);
        owm_ovl_cfg_t c;
        c.show       = r[O_SHOW];
        c.frame_mode = r[O_FRM];
        c.key_en     = r[O_KEY];
        c.table_ram  = r[O_TBL];
        c.rgb        = r[O_RGB] & gate;
        c.squeeze    = r[O_SQZ] & gate;
        c.mix        = r[O_MIX +: 3];
        c.bpp        = bpp_dec(r[O_BPP +: 2], r[O_RGB] & gate);
        c.hmag       = zoom_mag(r[O_HZ +: 2]);
        c.vmag       = zoom_mag(r[O_VZ +: 2]);
        ovl_dec = c;
    endfunction

    function automatic logic [7:0] clamp8(input logic signed [19:0] v);
        logic signed [19:0] s;
        s = v >>> 8;
        if (s < 0) begin
            clamp8 = 8'h00;
        end else if (s > 20'sd255) begin
            clamp8 = 8'hff;
        end else begin
            clamp8 = s[7:0];
        end
    endfunction

    function automatic logic [7:0] squeeze8(input logic [7:0] v, input logic [15:0] gain);
        logic [15:0] p;
        p = {8'h00, v} * gain;
        squeeze8 = SQZ_BASE + p[15:8];
    endfunction

    function automatic logic [7:0] blend8(input logic [7:0] o, input logic [7:0] v,
                                          input logic [3:0] w);
        logic [11:0] s;
        s = ({4'h0, o} * {8'h00, w}) + ({4'h0, v} * {8'h00, MIX_FULL - w});
        blend8 = s[10:3];
    endfunction

    // ---------------------------------------------------------------
    // avalon slave: one wait state, unmapped reads give zero
    // ---------------------------------------------------------------
    logic [31:0] mode_reg;
    logic [31:0] vid_reg;
    logic [31:0] ovl0_reg;
    logic [31:0] ovl1_reg;
    logic [31:0] key_reg;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;
    logic        ack_reg;
    logic        wr_take;

    assign waitrequest = (read | write) & ~ack_reg;
    assign wr_take     = write & ack_reg;

    // ack rises one cycle after the request so the master sees one wait state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    // status shows the settings the display is using now, not the pending ones
    assign stat_word = {26'h0, filter_active, ovl1_attr_mode, ovl1_cfg.show,
                        ovl0_cfg.show, vid1_cfg.show, vid0_cfg.show};

    // read decode
    always_comb begin
        unique case (address)
            OFS_MODE: rd_mux = mode_reg;
            OFS_VID:  rd_mux = vid_reg;
            OFS_OVL0: rd_mux = ovl0_reg;
            OFS_OVL1: rd_mux = ovl1_reg;
            OFS_KEY:  rd_mux = key_reg;
            OFS_STAT: rd_mux = stat_word;
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured a cycle early so it stands when waitrequest drops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack_reg) begin
            readdata <= rd_mux;
        end
    end

    // software registers; writes take effect only on the accepting edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_reg <= RST_MODE;
            vid_reg  <= RST_VID;
            ovl0_reg <= RST_OVL;
            ovl1_reg <= RST_OVL;
            key_reg  <= RST_KEY;
        end else if (wr_take) begin
            unique case (address)
                OFS_MODE: mode_reg <= merge_be(mode_reg, writedata, byteenable, MASK_MODE);
                OFS_VID:  vid_reg  <= merge_be(vid_reg, writedata, byteenable, MASK_VID);
                OFS_OVL0: ovl0_reg <= merge_be(ovl0_reg, writedata, byteenable, MASK_OVL0);
                OFS_OVL1: ovl1_reg <= merge_be(ovl1_reg, writedata, byteenable, MASK_OVL1);
                OFS_KEY:  key_reg  <= merge_be(key_reg, writedata, byteenable, MASK_KEY);
                default:  ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // frame-sync shadows
    // ---------------------------------------------------------------
    logic smooth_sh;
    logic flip_sh;
    logic v0_split_sh;
    logic v1_split_sh;

    // a write in the sync cycle itself lands next frame: shadows see the old word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vid0_cfg       <= '0;
            vid1_cfg       <= '0;
            ovl0_cfg       <= '0;
            ovl1_cfg       <= '0;
            ovl1_attr_mode <= 1'b0;
            vid_stretch_on <= 1'b0;
            smooth_sh      <= 1'b0;
            flip_sh        <= 1'b0;
            v0_split_sh    <= 1'b0;
            v1_split_sh    <= 1'b0;
        end else if (frame_sync_pulse) begin                         // [R9] [R25]
            vid0_cfg.show       <= vid_reg[V0_SHOW];                  // [R8]
            vid0_cfg.frame_mode <= vid_reg[V0_FRM];
            vid0_cfg.hmag       <= zoom_mag(vid_reg[V0_HZ +: 2]);     // [R1]
            vid0_cfg.vmag       <= zoom_mag(vid_reg[V0_VZ +: 2]);     // [R1]
            vid1_cfg.show       <= vid_reg[V1_SHOW];                  // [R8]
            vid1_cfg.frame_mode <= vid_reg[V1_FRM];
            vid1_cfg.hmag       <= zoom_mag(vid_reg[V1_HZ +: 2]);     // [R1]
            vid1_cfg.vmag       <= zoom_mag(vid_reg[V1_VZ +: 2]);     // [R1]
            ovl0_cfg       <= ovl_dec(ovl0_reg, 1'b1);                // [R14] [R15] [R16] [R20]
            ovl1_cfg       <= ovl_dec(ovl1_reg, ~ovl1_reg[O_ATTR]);   // [R22]
            ovl1_attr_mode <= ovl1_reg[O_ATTR];                       // [R21]
            vid_stretch_on <= mode_reg[MODE_VSTR];                    // [R24]
            smooth_sh      <= mode_reg[MODE_SMOOTH];
            flip_sh        <= vid_reg[VID_FLIP];
            v0_split_sh    <= vid_reg[V0_SPLIT];
            v1_split_sh    <= vid_reg[V1_SPLIT];
        end
    end

    // ---------------------------------------------------------------
    // expansion filter qualification
    // ---------------------------------------------------------------
    logic smooth_eff;

    // filter memory holds one 720-pixel line, so wider lines leave it off
    assign smooth_eff      = smooth_sh & vid_stretch_on;                      // [R23]
    assign filter_active   = smooth_eff & (vid_line_width <= LINE_MAX);       // [R23]
    assign vid0_coef_split = v0_split_sh & vid_stretch_on & smooth_sh;        // [R4]
    assign vid1_coef_split = v1_split_sh & vid_stretch_on & smooth_sh;        // [R3]
    assign coef_invert     = (vid0_coef_split | vid1_coef_split) & ~flip_sh;  // [R2]

    // ---------------------------------------------------------------
    // 6/5 stretch: one source line in five is shown twice
    // ---------------------------------------------------------------
    logic [2:0] str_cnt_reg;

    always_ff @(posedge clk) begin
        if (!rst_n || frame_sync_pulse) begin
            str_cnt_reg    <= 3'd0;
            stretch_repeat <= 1'b0;
        end else if (line_pulse && vid_stretch_on) begin             // [R24]
            stretch_repeat <= (str_cnt_reg == STR_LAST);
            str_cnt_reg    <= (str_cnt_reg == STR_LAST) ? 3'd0 : str_cnt_reg + 3'd1;
        end else if (line_pulse) begin
            stretch_repeat <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // line fetch pattern per window, fixed for the coming field
    // ---------------------------------------------------------------
    // frame mode reads every other stored line starting at the field parity;
    // field mode reads every line once (line doubling comes from the encoder)
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vid0_fetch <= '0;
            vid1_fetch <= '0;
            ovl0_fetch <= '0;
            ovl1_fetch <= '0;
        end else if (frame_sync_pulse) begin
            vid0_fetch <= '{vid_reg[V0_FRM], vid_reg[V0_FRM] & field_odd};   // [R5] [R6]
            vid1_fetch <= '{vid_reg[V1_FRM], vid_reg[V1_FRM] & field_odd};   // [R5] [R6]
            ovl0_fetch <= '{ovl0_reg[O_FRM], ovl0_reg[O_FRM] & field_odd};   // [R5] [R6]
            ovl1_fetch <= '{ovl1_reg[O_FRM], ovl1_reg[O_FRM] & field_odd};   // [R5] [R6]
        end
    end

    // ---------------------------------------------------------------
    // overlay pixel path: convert, squeeze, key, blend
    // ---------------------------------------------------------------
    owm_ovl_cfg_t       cfg;
    owm_ycc_t           conv;
    owm_ycc_t           colour;
    owm_ycc_t           mixed;
    logic               attr_pix;
    logic               keyed;
    logic [3:0]         weight;
    logic [15:0]        idx_mask;
    logic signed [19:0] r8;
    logic signed [19:0] g8;
    logic signed [19:0] b8;

    always_comb begin
        cfg      = pix_ovl_sel ? ovl1_cfg : ovl0_cfg;
        attr_pix = pix_ovl_sel & ovl1_attr_mode;
        // rgb565 widened to 8 bits by replicating the top bits
        r8 = {12'h000, pix_raw[15:11], pix_raw[15:13]};
        g8 = {12'h000, pix_raw[10:5], pix_raw[10:9]};
        b8 = {12'h000, pix_raw[4:0], pix_raw[4:2]};
        conv.y  = clamp8(K_Y_R * r8 + K_Y_G * g8 + K_Y_B * b8);                // [R11]
        conv.cb = clamp8(K_OFS - K_CB_R * r8 - K_CB_G * g8 + K_CB_B * b8);     // [R12]
        conv.cr = clamp8(K_OFS + K_CR_R * r8 - K_CR_G * g8 - K_CR_B * b8);     // [R12]
        // both overlays in rgb is a software fault; each pixel follows its own bit
        colour = cfg.rgb ? conv : pix_pal;                                     // [R11]
        if (cfg.squeeze && !ovl1_attr_mode) begin                             // [R10]
            colour.y  = squeeze8(colour.y, SQZ_GY);
            colour.cb = squeeze8(colour.cb, SQZ_GC);
            colour.cr = squeeze8(colour.cr, SQZ_GC);
        end
        idx_mask = (16'h0001 << cfg.bpp[3:0]) - 16'h0001;
        if (cfg.rgb) begin
            keyed = (pix_raw == key_reg[15:0]);                               // [R19]
        end else begin
            keyed = ((pix_raw & idx_mask) == 16'h0000);                       // [R18]
        end
        // key off blends everything; key on blends only keyed pixels
        weight = (!cfg.key_en || keyed) ? ((cfg.mix == 3'h7) ? MIX_FULL     // [R17] [R18]
                                                             : {1'b0, cfg.mix})
                                        : MIX_FULL;
        mixed.y  = blend8(colour.y, pix_vid.y, weight);                       // [R17]
        mixed.cb = blend8(colour.cb, pix_vid.cb, weight);
        mixed.cr = blend8(colour.cr, pix_vid.cr, weight);
    end

    // hidden windows and attribute pixels pass video through unchanged
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_pix   <= '0;
        end else begin
            out_valid <= pix_valid;
            if (pix_valid) begin
                out_pix <= (cfg.show && !attr_pix) ? mixed : pix_vid;         // [R20]
            end
        end
    end

endmodule // owm_window_mode

//--- owm_window_mode_asserts.sv
// Purpose: port-level checks for the window mode block
// Assumes: one display clock, synchronous active-low reset
// Notes:   bound onto every instance; sees ports only
`timescale 1ns/1ps
module owm_chk
    import owm_pkg::*;
(
    input logic         clk,              // display clock
    input logic         rst_n,            // sync reset, active low
    input logic         frame_sync_pulse, // shadow load strobe
    input owm_vid_cfg_t vid0_cfg,         // video window 0 shadow
    input owm_ovl_cfg_t ovl0_cfg,         // overlay 0 shadow
    input logic         vid_stretch_on,   // vertical stretch shadow
    input logic         vid0_coef_split,  // per-field taps, window 0
    input logic         vid1_coef_split,  // per-field taps, window 1
    input logic         coef_invert,      // inverted taps
    input logic         pix_valid,        // pixel strobe
    input logic         pix_ovl_sel,      // overlay select
    input owm_ycc_t     pix_pal,          // palette colour
    input owm_ycc_t     pix_vid,          // video pixel
    input owm_ycc_t     out_pix           // mixed pixel
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // plain opaque bitmap pixel: no blend, no key, no conversion
    wire full0 = pix_valid && !pix_ovl_sel && ovl0_cfg.show && ovl0_cfg.mix == 3'h7
                 && !ovl0_cfg.key_en && !ovl0_cfg.rgb && !ovl0_cfg.squeeze;
    property p_hold; !frame_sync_pulse |=> $stable(vid0_cfg) && $stable(ovl0_cfg); endproperty
    a_hold: assert property (p_hold) else $error("settings moved off sync");
    property p_zoom; vid0_cfg.hmag != 3'h0 |-> vid0_cfg.hmag inside {3'h1, 3'h2, 3'h4}; endproperty
    a_zoom: assert property (p_zoom) else $error("bad video zoom");
    property p_bpp; ovl0_cfg.rgb |-> ovl0_cfg.bpp == 5'h10; endproperty
    a_bpp: assert property (p_bpp) else $error("rgb depth not 16");
    property p_flip; coef_invert |-> vid0_coef_split || vid1_coef_split; endproperty
    a_flip: assert property (p_flip) else $error("invert without split");
    property p_split0; vid0_coef_split |-> vid_stretch_on; endproperty
    a_split0: assert property (p_split0) else $error("split0 without stretch");
    property p_split1; vid1_coef_split |-> vid_stretch_on; endproperty
    a_split1: assert property (p_split1) else $error("split1 without stretch");
    property p_full; full0 |=> out_pix == $past(pix_pal); endproperty
    a_full: assert property (p_full) else $error("full weight mix wrong");
    property p_hide; pix_valid && !pix_ovl_sel && !ovl0_cfg.show |=> out_pix == $past(pix_vid); endproperty
    a_hide: assert property (p_hide) else $error("hidden overlay shown");
endmodule // owm_chk
bind owm_window_mode owm_chk u_chk (.*);

//--- tb_top.sv
// Purpose: register and pixel regression for the window mode block
// Assumes: 250 MHz clock, one wait state per bus access
// Notes:   only overlay 0 pixels are mixed
`timescale 1ns/1ps
module tb_top
    import owm_pkg::*;
;
    logic clk = 0, rst_n = 0, read = 0, write = 0, frame_sync_pulse = 0, pix_valid = 0;
    logic field_odd = 0, line_pulse = 0, pix_ovl_sel = 0, waitrequest, out_valid;
    logic ovl1_attr_mode, vid_stretch_on, stretch_repeat, filter_active;
    logic vid0_coef_split, vid1_coef_split, coef_invert;
    logic [7:0] address = 0;
    logic [3:0] byteenable = 4'hf;
    logic [10:0] vid_line_width = 11'h0;
    logic [15:0] pix_raw = 0;
    logic [31:0] writedata = 0, readdata, q;
    owm_vid_cfg_t vid0_cfg, vid1_cfg;
    owm_ovl_cfg_t ovl0_cfg, ovl1_cfg;
    owm_fetch_t vid0_fetch, vid1_fetch, ovl0_fetch, ovl1_fetch;
    owm_ycc_t pix_pal = 24'h102030, pix_vid = 24'h405060, out_pix;
    int n_fail = 0, comparisons = 0, c;
    int mag[4] = '{1, 2, 4, 1};
    int bw[4] = '{1, 2, 4, 8};
    owm_window_mode dut (.*);
    always #2 clk = ~clk;
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        read <= !wr; write <= wr; address <= a; writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0; write <= 0;
        @(posedge clk);
    endtask
    task automatic sync();
        frame_sync_pulse <= 1;
        @(posedge clk);
        frame_sync_pulse <= 0;
        @(posedge clk);
    endtask
    // one pixel, mixed result checked one cycle later
    task automatic px(input logic [15:0] raw, input logic [23:0] e);
        pix_valid <= 1; pix_raw <= raw;
        @(posedge clk);
        pix_valid <= 0;
        #1 chk(out_pix, e);
        @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard: whole run is about a hundred cycles
    initial begin
        #40000 n_fail++;
        stop_test();
    end
    // ---------------------------------------------------------------
    // sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        bus(0, OFS_VID, 0); chk(q, RST_VID);
        bus(0, 8'h40, 0); chk(q, 32'h0);
        px(16'h0001, 24'h405060);
        for (c = 0; c < 4; c++) begin
            bus(1, OFS_VID, (c << V0_HZ) | (c << V0_VZ) | 1);
            bus(1, OFS_OVL0, (c << O_HZ) | (c << O_VZ) | (c << O_BPP) | (7 << O_MIX) | 1);
            chk(vid0_cfg.vmag, c ? mag[c-1] : 0);
            sync();
            chk(vid0_cfg.hmag, mag[c]); chk(vid0_cfg.show, 1);
            chk(ovl0_cfg.vmag, mag[c]); chk(ovl0_cfg.bpp, bw[c]);
        end
        px(16'h0001, 24'h102030);
        bus(1, OFS_OVL0, (4 << O_MIX) | 1); sync();
        px(16'h0001, 24'h283848);
        bus(1, OFS_OVL0, (3 << O_BPP) | (1 << O_KEY) | 1); sync();
        px(16'h0100, 24'h405060); px(16'h0001, 24'h102030);
        bus(1, OFS_OVL0, (1 << O_RGB) | (7 << O_MIX) | 1); sync();
        chk(ovl0_cfg.bpp, 16); px(16'hffff, 24'hff8080);
        bus(1, OFS_OVL0, (1 << O_SQZ) | (1 << O_RGB) | (7 << O_MIX) | 1); sync();
        px(16'hffff, 24'hea8080);
        bus(1, OFS_OVL1, 1 << O_ATTR); sync();
        chk(ovl1_attr_mode, 1); px(16'hffff, 24'hff8080);
        field_odd <= 1; bus(1, OFS_MODE, 32'h1800);
        bus(1, OFS_VID, 32'h4343); sync();
        chk({vid_stretch_on, filter_active, vid0_fetch}, 4'hf);
        chk({coef_invert, vid0_coef_split, vid1_coef_split}, 3'h7);
        line_pulse <= 1; vid_line_width <= 11'd721; repeat (5) @(posedge clk);
        line_pulse <= 0;
        #1 chk({stretch_repeat, filter_active, ovl0_fetch}, 4'h8);
        stop_test();
    end
endmodule // tb_top
